// ===== spicp_core.sv
`timescale 1ns/1ps
// Operation
// - 00iiii00 reads register reg_index4 directly
// - 10xxxxxx writes register reg_index6 directly
// - fast access moves one word, then the core ignores the rest of the frame
// - four pointers at 0x0b..0x0e, one enabled
// - select field bits 11:10 of register 0
// - opcodes d8..db set the select field
// - 8b..8e plus word loads a pointer
// - 2c/30/34/38 shift out a pointer
// - each indirect word advances the pointer
// - pointer wraps from 0x1fff to 0x0000
// - d0/d2/d4 add 1/2/4 to pointer
// - fast write uses private pointer only, fast read takes the address from the command bits
// - 40 reads, c0 writes at pointer
// - single byte command: add one, then write
// - command msb gives direction, one writes
// - words high byte first, msb first
// - chip select rise ends and resets transfer
// - output tristate unless sending, input ignored
module spicp_core
    import spicp_pkg::*;
(
    input  logic        CLK,
    input  logic        SYS_RST,
    input  logic        SCK,
    input  logic        CE_N,
    input  logic        SI,
    output logic        SO,
    output logic        SO_OE,
    output logic [12:0] MEM_ADDR,
    output logic [15:0] MEM_WDATA,
    output logic        MEM_WR,
    output logic        MEM_RD,
    input  logic [15:0] MEM_RDATA,
    output logic [1:0]  POINTER_SELECT
);

    // =====================================================================
    // link domain and crossings
    logic [15:0] tx_word_ff;
    logic [7:0]  rx_byte;
    logic        rx_tgl;
    logic        rx_tgl_s;
    logic        ce_n_s;

    spicp_link u_link (
        .sck     (SCK),
        .ce_n    (CE_N),
        .si      (SI),
        .tx_word (tx_word_ff),
        .rx_byte (rx_byte),
        .rx_tgl  (rx_tgl),
        .so_data (SO),
        .so_oe   (SO_OE)
    );

    spicp_sync #(.RST_VAL(1'b1)) u_ce_sync (
        .clk (CLK),
        .rst (SYS_RST),
        .d   (CE_N),
        .q   (ce_n_s)
    );

    spicp_sync #(.RST_VAL(1'b0)) u_rx_sync (
        .clk (CLK),
        .rst (SYS_RST),
        .d   (rx_tgl),
        .q   (rx_tgl_s)
    );

    // =====================================================================
    // state
    spicp_state_t state_ff;
    spicp_state_t nxt_state;
    logic [15:0]  ptr_ff [0:3];
    logic [1:0]   sel_ff;
    logic [5:0]   int_ptr_ff;
    logic [5:0]   nxt_int_ptr;
    logic [7:0]   hi_ff;
    logic [7:0]   nxt_hi;
    logic         phase_ff;
    logic         nxt_phase;
    logic         fast_ff;
    logic         nxt_fast;
    logic         rx_seen_ff;
    logic         rd_pend_ff;
    logic         rd_cfg_ff;

    // =====================================================================
    // decode
    logic        frame_on;
    logic        byte_evt;
    logic [7:0]  cmd;
    logic        is_fast_rd;
    logic        is_fast_wr;
    logic        is_adj;
    logic        is_sel;
    logic [15:0] cur_ptr;
    logic [12:0] adj_amt;
    logic [15:0] ptr_inc1;
    logic [15:0] ptr_adj;

    assign frame_on   = ~ce_n_s;
    assign byte_evt   = frame_on && (rx_tgl_s != rx_seen_ff);
    assign cmd        = rx_byte;
    assign is_fast_rd = (cmd[7:6] == FAST_RD_TOP) && (cmd[1:0] == FAST_RD_LOW);
    assign is_fast_wr = (cmd[7:6] == FAST_WR_TOP);
    assign is_adj     = (cmd == OP_ADD1) || (cmd == OP_ADD2) || (cmd == OP_ADD4);
    assign is_sel     = (cmd[7:2] == OP_SEL_TOP);
    assign cur_ptr    = ptr_ff[sel_ff];
    assign adj_amt    = (cmd == OP_ADD4) ? STEP4 : ((cmd == OP_ADD2) ? STEP2 : STEP1);
    assign ptr_inc1   = {3'h0, cur_ptr[12:0] + STEP1};
    assign ptr_adj    = {3'h0, cur_ptr[12:0] + adj_amt};

    // =====================================================================
    // command sequencer
    logic        ptr_we;
    logic [15:0] ptr_wval;
    logic        sel_we;
    logic        rd_go;
    logic [12:0] rd_addr;
    logic        wr_go;
    logic [12:0] wr_addr;

    always_comb begin
        nxt_state   = state_ff;
        nxt_int_ptr = int_ptr_ff;
        nxt_hi      = hi_ff;
        nxt_phase   = phase_ff;
        nxt_fast    = fast_ff;
        ptr_we      = 1'b0;
        ptr_wval    = ptr_inc1;
        sel_we      = 1'b0;
        rd_go       = 1'b0;
        rd_addr     = cur_ptr[12:0];
        wr_go       = 1'b0;
        wr_addr     = cur_ptr[12:0];
        if (byte_evt) begin
            unique case (state_ff)
                ST_CMD: begin
                    nxt_phase = 1'b0;
                    nxt_state = ST_IGNORE;
                    if (is_fast_rd) begin
                        rd_go     = 1'b1;
                        rd_addr   = {9'h000, cmd[5:2]};
                        nxt_fast  = 1'b1;
                        nxt_state = ST_RD;
                    end else if (cmd == OP_READ_PTR) begin
                        rd_go     = 1'b1;
                        nxt_fast  = 1'b0;
                        nxt_state = ST_RD;
                    end else if (is_fast_wr) begin
                        nxt_int_ptr = cmd[5:0];
                        nxt_fast    = 1'b1;
                        nxt_state   = ST_WR_HI;
                    end else if (cmd == OP_WRITE_PTR) begin
                        nxt_fast  = 1'b0;
                        nxt_state = ST_WR_HI;
                    end else if (cmd == OP_INC_WRITE) begin
                        ptr_we    = 1'b1;
                        nxt_fast  = 1'b0;
                        nxt_state = ST_WR_HI;
                    end else if (is_adj) begin
                        ptr_we   = 1'b1;
                        ptr_wval = ptr_adj;
                    end else if (is_sel) begin
                        sel_we = 1'b1;
                    end
                end
                ST_RD: begin
                    nxt_phase = ~phase_ff;
                    if (phase_ff) begin
                        if (fast_ff) begin
                            nxt_state = ST_IGNORE;
                        end else begin
                            ptr_we  = 1'b1;
                            rd_go   = 1'b1;
                            rd_addr = ptr_inc1[12:0];
                        end
                    end
                end
                ST_WR_HI: begin
                    nxt_hi    = cmd;
                    nxt_state = ST_WR_LO;
                end
                ST_WR_LO: begin
                    wr_go = 1'b1;
                    if (fast_ff) begin
                        wr_addr   = {7'h00, int_ptr_ff};
                        nxt_state = ST_IGNORE;
                    end else begin
                        ptr_we    = 1'b1;
                        nxt_state = ST_WR_HI;
                    end
                end
                ST_IGNORE: begin
                    nxt_state = ST_IGNORE;
                end
            endcase
        end
    end

    // =====================================================================
    // target decode: pointers and the select field live here
    logic [15:0] wr_data;
    logic [12:0] wr_off;
    logic [12:0] rd_off;
    logic        wr_ptr_hit;
    logic        rd_ptr_hit;
    logic        wr_cfg_hit;

    assign wr_data    = {hi_ff, cmd};
    assign wr_off     = wr_addr - PTR_BASE_ADDR;
    assign rd_off     = rd_addr - PTR_BASE_ADDR;
    assign wr_ptr_hit = (wr_addr >= PTR_BASE_ADDR) && (wr_addr <= PTR_LAST_ADDR);
    assign rd_ptr_hit = (rd_addr >= PTR_BASE_ADDR) && (rd_addr <= PTR_LAST_ADDR);
    assign wr_cfg_hit = (wr_addr == CFG_ADDR);

    // =====================================================================
    // registers
    always_ff @(posedge CLK) begin
        if (SYS_RST || !frame_on) begin
            state_ff <= ST_CMD;
            phase_ff <= 1'b0;
            fast_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            phase_ff <= nxt_phase;
            fast_ff  <= nxt_fast;
        end
    end

    // tracking the toggle while idle hides the link's reset-to-zero
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            rx_seen_ff <= 1'b0;
            int_ptr_ff <= 6'h00;
            hi_ff      <= 8'h00;
        end else begin
            rx_seen_ff <= rx_tgl_s;
            int_ptr_ff <= nxt_int_ptr;
            hi_ff      <= nxt_hi;
        end
    end

    // a word write to a pointer address wins over the auto-increment
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            for (int i = 0; i < 4; i++) begin
                ptr_ff[i] <= PTR_RESET;
            end
        end else if (wr_go && wr_ptr_hit) begin
            ptr_ff[wr_off[1:0]] <= wr_data;
        end else if (ptr_we) begin
            ptr_ff[sel_ff] <= ptr_wval;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            sel_ff <= SEL_RESET;
        end else if (sel_we) begin
            sel_ff <= cmd[1:0];
        end else if (wr_go && wr_cfg_hit) begin
            sel_ff <= wr_data[SEL_HI:SEL_LO];
        end
    end

    // =====================================================================
    // memory port and read word
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            MEM_RD     <= 1'b0;
            MEM_WR     <= 1'b0;
            MEM_ADDR   <= 13'h0000;
            MEM_WDATA  <= 16'h0000;
            rd_pend_ff <= 1'b0;
            rd_cfg_ff  <= 1'b0;
        end else begin
            MEM_RD     <= rd_go && !rd_ptr_hit;
            MEM_WR     <= wr_go && !wr_ptr_hit;
            rd_pend_ff <= rd_go && !rd_ptr_hit;
            rd_cfg_ff  <= rd_addr == CFG_ADDR;
            if (rd_go) begin
                MEM_ADDR <= rd_addr;
            end else if (wr_go) begin
                MEM_ADDR  <= wr_addr;
                MEM_WDATA <= wr_data;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            tx_word_ff <= 16'h0000;
        end else if (rd_go && rd_ptr_hit) begin
            tx_word_ff <= ptr_ff[rd_off[1:0]];
        end else if (rd_pend_ff) begin
            tx_word_ff <= MEM_RDATA;
            if (rd_cfg_ff) begin
                tx_word_ff[SEL_HI:SEL_LO] <= sel_ff;
            end
        end
    end

    assign POINTER_SELECT = sel_ff;

endmodule

// ===== spicp_core_properties.sv
`timescale 1ns/1ps
module spicp_core_chk
    import spicp_pkg::*;
(
    input logic        CLK,
    input logic        SYS_RST,
    input logic        SCK,
    input logic        CE_N,
    input logic        SI,
    input logic        SO_OE,
    input logic [12:0] MEM_ADDR,
    input logic [15:0] MEM_WDATA,
    input logic        MEM_WR,
    input logic        MEM_RD,
    input logic [1:0]  POINTER_SELECT
);
    // ==========================================================
    // helpers
    logic [3:0] rise_cnt_ff;
    logic [3:0] idle_cnt_ff;
    logic [7:0] cmd_ff;
    wire  [3:0] nxt_rise_cnt = (rise_cnt_ff == 4'hf) ? rise_cnt_ff : rise_cnt_ff + 4'h1;
    wire  [3:0] nxt_idle_cnt = !CE_N ? 4'h0 : (idle_cnt_ff == 4'hf) ? 4'hf : idle_cnt_ff + 4'h1;
    wire  [7:0] nxt_cmd      = (rise_cnt_ff < 4'h8) ? {cmd_ff[6:0], SI} : cmd_ff;
    wire        fast_rd      = (cmd_ff[7:6] == FAST_RD_TOP) && (cmd_ff[1:0] == FAST_RD_LOW);

    // chip select high clears the link side, so the bit count restarts per frame
    always_ff @(posedge SCK or posedge CE_N) begin
        if (CE_N)
            rise_cnt_ff <= 4'h0;
        else
            rise_cnt_ff <= nxt_rise_cnt;
    end
    always_ff @(posedge SCK) cmd_ff <= nxt_cmd;
    always_ff @(posedge CLK) begin
        if (SYS_RST)
            idle_cnt_ff <= 4'h0;
        else
            idle_cnt_ff <= nxt_idle_cnt;
    end

    // ==========================================================
    // assertions
    chk_wr_one_pulse: assert property (@(posedge CLK) disable iff (SYS_RST)
        MEM_WR |=> !MEM_WR && !MEM_RD) else $error("write strobe not single");
    chk_rd_addr_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
        MEM_RD |=> !MEM_RD && !MEM_WR && $stable(MEM_ADDR)) else $error("read strobe bad");
    chk_ptr_wr_local: assert property (@(posedge CLK) disable iff (SYS_RST)
        MEM_WR |-> (MEM_ADDR < PTR_BASE_ADDR || MEM_ADDR > PTR_LAST_ADDR))
        else $error("pointer write leaked to memory");
    chk_cfg_sel_follow: assert property (@(posedge CLK) disable iff (SYS_RST)
        MEM_WR && MEM_ADDR == CFG_ADDR |-> ##[0:2] POINTER_SELECT == MEM_WDATA[SEL_HI:SEL_LO])
        else $error("select did not follow config write");
    chk_idle_quiet: assert property (@(posedge CLK) disable iff (SYS_RST)
        idle_cnt_ff >= 4'h8 |-> !MEM_WR && !MEM_RD) else $error("access outside frame");
    chk_oe_after_cmd: assert property (@(posedge SCK) disable iff (CE_N)
        rise_cnt_ff < 4'h8 |-> !SO_OE) else $error("output on during command byte");
    chk_fast_rd_drive: assert property (@(posedge SCK) disable iff (CE_N)
        rise_cnt_ff == 4'h8 && fast_rd |-> SO_OE) else $error("fast read not driving");
    chk_oe_in_frame: assert property (@(posedge CLK) disable iff (SYS_RST)
        $rose(SO_OE) |-> !CE_N) else $error("output enabled outside frame");
    chk_oe_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
        $fell(SO_OE) |-> CE_N) else $error("output dropped inside frame");
    chk_idle_oe_off: assert property (@(posedge CLK) disable iff (SYS_RST)
        CE_N && $past(CE_N) |-> !SO_OE) else $error("output on while idle");
endmodule

bind spicp_core spicp_core_chk u_spicp_core_chk (
    .CLK(CLK), .SYS_RST(SYS_RST), .SCK(SCK), .CE_N(CE_N), .SI(SI), .SO_OE(SO_OE),
    .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_WR(MEM_WR), .MEM_RD(MEM_RD),
    .POINTER_SELECT(POINTER_SELECT)
);

// ===== spicp_core_tb_top.sv
`timescale 1ns/1ps
module spicp_core_tb_top
    import spicp_pkg::*;
;
    typedef struct {
        logic [7:0]  cmd;
        int          nw;
        logic [15:0] wd;
        logic [15:0] xv;
        logic [12:0] xa;
        int          xn;
        logic [1:0]  xs;
    } spicp_row_t;

    logic        clk;
    logic        sys_rst;
    logic        sck;
    logic        ce_n;
    logic        si;
    logic        so;
    logic        so_oe;
    logic [12:0] mem_addr;
    logic [15:0] mem_wdata;
    logic        mem_wr;
    logic        mem_rd;
    logic [15:0] mem_rdata;
    logic [1:0]  pointer_select;
    logic [15:0] mem [8192];
    logic [12:0] lwa;
    logic [15:0] lwd;
    int          nwr;
    int          n_fail;
    int          samples_checked;
    int          cyc;
    int          r;
    int          k;
    spicp_row_t  rows [35] = '{
        '{8'h80, 1, 16'h800, 16'h800, 13'h0, 1, 2'h2}, '{8'hd9, 0, 16'h0, 16'h0, 13'h0, 0, 2'h1},
        '{8'hda, 0, 16'h0, 16'h0, 13'h0, 0, 2'h2}, '{8'hdb, 0, 16'h0, 16'h0, 13'h0, 0, 2'h3},
        '{8'hd8, 0, 16'h0, 16'h0, 13'h0, 0, 2'h0}, '{8'h8b, 1, 16'h100, 16'h0, 13'h0, 0, 2'h0},
        '{8'h2c, 1, 16'h0, 16'h100, 13'h0, 0, 2'h0}, '{8'h40, 2, 16'h0, 16'h0, 13'h100, 0, 2'h0},
        '{8'h2c, 1, 16'h0, 16'h102, 13'h0, 0, 2'h0}, '{8'hd0, 0, 16'h0, 16'h0, 13'h0, 0, 2'h0},
        '{8'hd2, 0, 16'h0, 16'h0, 13'h0, 0, 2'h0}, '{8'hd4, 0, 16'h0, 16'h0, 13'h0, 0, 2'h0},
        '{8'h2c, 1, 16'h0, 16'h109, 13'h0, 0, 2'h0},
        '{8'hc0, 2, 16'h1234, 16'h1235, 13'h10a, 2, 2'h0},
        '{8'hc4, 1, 16'h5555, 16'h5555, 13'h10c, 1, 2'h0},
        '{8'h2c, 1, 16'h0, 16'h10d, 13'h0, 0, 2'h0}, '{8'h3c, 1, 16'h0, 16'h0, 13'hf, 0, 2'h0},
        '{8'h81, 2, 16'haaa, 16'haaa, 13'h1, 1, 2'h0}, '{8'h04, 1, 16'h0, 16'haaa, 13'h0, 0, 2'h0},
        '{8'h2c, 1, 16'h0, 16'h10d, 13'h0, 0, 2'h0}, '{8'hd9, 0, 16'h0, 16'h0, 13'h0, 0, 2'h1},
        '{8'h8c, 1, 16'h1fff, 16'h0, 13'h0, 0, 2'h1}, '{8'h30, 1, 16'h0, 16'h1fff, 13'h0, 0, 2'h1},
        '{8'h40, 1, 16'h0, 16'h0, 13'h1fff, 0, 2'h1}, '{8'h30, 1, 16'h0, 16'h0, 13'h0, 0, 2'h1},
        '{8'hda, 0, 16'h0, 16'h0, 13'h0, 0, 2'h2}, '{8'h8d, 1, 16'h1ffe, 16'h0, 13'h0, 0, 2'h2},
        '{8'hd4, 0, 16'h0, 16'h0, 13'h0, 0, 2'h2}, '{8'h34, 1, 16'h0, 16'h2, 13'h0, 0, 2'h2},
        '{8'hdb, 0, 16'h0, 16'h0, 13'h0, 0, 2'h3}, '{8'h8e, 1, 16'habc, 16'h0, 13'h0, 0, 2'h3},
        '{8'h38, 1, 16'h0, 16'habc, 13'h0, 0, 2'h3}, '{8'h2c, 1, 16'h0, 16'h10d, 13'h0, 0, 2'h3},
        '{8'hcc, 1, 16'hffff, 16'h0, 13'h0, 0, 2'h3}, '{8'h38, 1, 16'h0, 16'habc, 13'h0, 0, 2'h3}
    };

    spicp_core u_spicp_core (
        .CLK(clk), .SYS_RST(sys_rst), .SCK(sck), .CE_N(ce_n), .SI(si), .SO(so),
        .SO_OE(so_oe), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_WR(mem_wr),
        .MEM_RD(mem_rd), .MEM_RDATA(mem_rdata), .POINTER_SELECT(pointer_select)
    );
    spicp_host_model u_spicp_host_model (
        .sck(sck), .ce_n(ce_n), .si(si), .so_data(so), .so_en(so_oe)
    );

    // ==========================================================
    // clock, memory behind the block, timeout
    initial clk = 1'b0;
    always #5 clk = ~clk;
    always @(negedge clk) begin
        if (mem_rd)
            mem_rdata <= mem[mem_addr];
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (mem_wr) begin
            mem[mem_addr] <= mem_wdata;
            nwr++;
            lwa <= mem_addr;
            lwd <= mem_wdata;
        end
        if (cyc == 10000) begin
            n_fail++;
            final_report();
        end
    end

    // ==========================================================
    // helpers
    function automatic logic [15:0] exp_mem(input logic [12:0] a);
        return {3'h0, a} ^ 16'h5a5a;
    endfunction
    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: word %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_addr(input logic [12:0] got, input logic [12:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: value %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic run(input logic [7:0] cmd, input int nw, input logic [15:0] wd, input int cut);
        nwr = 0;
        @(negedge clk);
        u_spicp_host_model.xfer(cmd, nw, wd, cut);
        repeat (8) @(negedge clk);
    endtask
    task automatic final_report();
        $display("checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        sys_rst = 1'b1;
        mem_rdata = 16'h0;
        for (r = 0; r < 8192; r++)
            mem[r] = exp_mem(13'(r));
        repeat (10) @(negedge clk);
        cmp_addr({10'h0, so_oe, mem_wr, mem_rd}, 13'h0);
        cmp_addr(mem_addr, 13'h0);
        cmp_addr({11'h0, pointer_select}, {11'h0, SEL_RESET});
        sys_rst = 1'b0;
        repeat (4) @(negedge clk);
        for (r = 0; r < 35; r++) begin
            run(rows[r].cmd, rows[r].nw, rows[r].wd, 0);
            if (!rows[r].cmd[7] && rows[r].nw > 0) begin
                for (k = 0; k < rows[r].nw; k++)
                    cmp_word(u_spicp_host_model.rw[k], (rows[r].xa == 13'h0) ? rows[r].xv
                      : exp_mem(rows[r].xa + 13'(k)));
            end else begin
                cmp_addr(13'(nwr), 13'(rows[r].xn));
                if (rows[r].xn > 0) begin
                    cmp_addr(lwa, rows[r].xa);
                    cmp_word(lwd, rows[r].xv);
                end
            end
            cmp_addr({11'h0, pointer_select}, {11'h0, rows[r].xs});
        end
        // partial byte at chip select rise must leave nothing behind
        run(8'h82, 1, 16'h1111, 12);
        cmp_addr(13'(nwr), 13'h0);
        run(8'h82, 1, 16'h2222, 0);
        cmp_addr(lwa, 13'h2);
        cmp_word(lwd, 16'h2222);
        // second reset in mid-run
        sys_rst = 1'b1;
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk);
        run(8'h2c, 1, 16'h0, 0);
        cmp_word(u_spicp_host_model.rw[0], PTR_RESET);
        cmp_addr({11'h0, pointer_select}, {11'h0, SEL_RESET});
        final_report();
    end
endmodule

// ===== spicp_host_model.sv
`timescale 1ns/1ps
module spicp_host_model (
    output logic sck,
    output logic ce_n,
    output logic si,
    input  logic so_data,
    input  logic so_en
);
    logic [15:0] rw [2];

    // ==========================================================
    // mode 0 master; clock stands low between frames
    initial begin
        sck = 1'b0;
        ce_n = 1'b0;
        si = 1'b0;
        // a real rising edge clears the link logic out of its unknown state
        #1 ce_n = 1'b1;
    end

    task automatic xfer(input logic [7:0] cmd, input int nw, input logic [15:0] wd, input int cut);
        logic [15:0] cur;
        logic [15:0] sh;
        int          i;
        int          b;
        #3.3 ce_n = 1'b0;
        for (i = 0; i < 8 + 16 * nw && (cut == 0 || i < cut); i++) begin
            b = (i - 8) % 16;
            cur = wd + 16'((i - 8) / 16);
            if (i < 8)
                si = cmd[7 - i];
            else if (!cmd[7])
                si = i[0];
            else
                si = cur[15 - b];
            #7.5 sck = 1'b1;
            sh = {sh[14:0], so_en ? so_data : 1'bz};
            if (i >= 8 && b == 15)
                rw[(i - 8) / 16] = sh;
            // read words are fetched on the system clock: give them time
            if (!cmd[7] && (i == 7 || b == 15))
                #110;
            #7.5 sck = 1'b0;
        end
        #5 ce_n = 1'b1;
        si = ~si;
        #60;
    endtask
endmodule

// ===== spicp_link.sv
`timescale 1ns/1ps
module spicp_link
    import spicp_pkg::*;
(
    input  logic        sck,
    input  logic        ce_n,
    input  logic        si,
    input  logic [15:0] tx_word,
    output logic [7:0]  rx_byte,
    output logic        rx_tgl,
    output logic        so_data,
    output logic        so_oe
);

    logic [2:0] bit_cnt_ff;
    logic [6:0] sh_ff;
    logic       first_ff;
    logic       rd_mode_ff;
    logic [3:0] tx_idx_ff;
    logic       tx_on_ff;
    logic       si_eff;
    logic [7:0] byte_in;
    logic       is_rd_cmd;
    logic [3:0] nxt_tx_idx;

    // =====================================================================
    // receive side, rising edges; chip select high clears everything but rx_byte
    assign si_eff    = tx_on_ff ? 1'b0 : si;
    assign byte_in   = {sh_ff, si_eff};
    assign is_rd_cmd = ((byte_in[7:6] == FAST_RD_TOP) && (byte_in[1:0] == FAST_RD_LOW))
                       || (byte_in == OP_READ_PTR);

    always_ff @(posedge sck or posedge ce_n) begin
        if (ce_n) begin
            bit_cnt_ff <= 3'h0;
            sh_ff      <= 7'h00;
            rx_tgl     <= 1'b0;
            first_ff   <= 1'b1;
            rd_mode_ff <= 1'b0;
        end else begin
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            sh_ff      <= byte_in[6:0];
            if (bit_cnt_ff == BIT_LAST) begin
                rx_tgl   <= ~rx_tgl;
                first_ff <= 1'b0;
                if (first_ff) begin
                    rd_mode_ff <= is_rd_cmd;
                end
            end
        end
    end

    // no chip select reset here: the core reads the last byte a few system
    // clocks after its final edge, often after chip select has gone high
    always_ff @(posedge sck) begin
        if (bit_cnt_ff == BIT_LAST) begin
            rx_byte <= byte_in;
        end
    end

    // =====================================================================
    // transmit side, falling edges; one bit per edge, words back to back
    // tx_word is only reloaded by the core while the host pauses sck, so
    // the bus may be read here without a synchroniser
    assign nxt_tx_idx = tx_on_ff ? (tx_idx_ff - 4'h1) : TX_MSB;

    always_ff @(negedge sck or posedge ce_n) begin
        if (ce_n) begin
            tx_on_ff  <= 1'b0;
            tx_idx_ff <= TX_MSB;
            so_data   <= 1'b0;
        end else if (rd_mode_ff) begin
            tx_on_ff  <= 1'b1;
            tx_idx_ff <= nxt_tx_idx;
            so_data   <= tx_word[nxt_tx_idx];
        end
    end

    assign so_oe = tx_on_ff;

endmodule

// ===== spicp_pkg.sv
package spicp_pkg;

    // =====================================================================
    // widths
    localparam int unsigned ADDR_W = 13;
    localparam int unsigned WORD_W = 16;
    localparam int unsigned IDX6_W = 6;

    // =====================================================================
    // register addresses and fields
    localparam logic [12:0] CFG_ADDR      = 13'h0000;
    localparam logic [12:0] PTR_BASE_ADDR = 13'h000b;
    localparam logic [12:0] PTR_LAST_ADDR = 13'h000e;
    localparam int unsigned SEL_HI        = 11;
    localparam int unsigned SEL_LO        = 10;
    localparam logic [1:0]  SEL_RESET     = 2'h0;
    localparam logic [15:0] PTR_RESET     = 16'h0000;

    // =====================================================================
    // command bytes
    localparam logic [1:0] FAST_RD_TOP = 2'h0;
    localparam logic [1:0] FAST_RD_LOW = 2'h0;
    localparam logic [1:0] FAST_WR_TOP = 2'h2;
    localparam logic [7:0] OP_READ_PTR  = 8'h40;
    localparam logic [7:0] OP_WRITE_PTR = 8'hc0;
    localparam logic [7:0] OP_INC_WRITE = 8'hc4;
    localparam logic [7:0] OP_ADD1      = 8'hd0;
    localparam logic [7:0] OP_ADD2      = 8'hd2;
    localparam logic [7:0] OP_ADD4      = 8'hd4;
    localparam logic [5:0] OP_SEL_TOP   = 6'h36;

    // =====================================================================
    // pointer steps
    localparam logic [12:0] STEP1 = 13'h0001;
    localparam logic [12:0] STEP2 = 13'h0002;
    localparam logic [12:0] STEP4 = 13'h0004;

    // =====================================================================
    // serial framing
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [3:0] TX_MSB   = 4'hf;

    typedef enum logic [2:0] {
        ST_CMD,
        ST_RD,
        ST_WR_HI,
        ST_WR_LO,
        ST_IGNORE
    } spicp_state_t;

endpackage

// ===== spicp_sync.sv
`timescale 1ns/1ps
module spicp_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input  logic clk,
    input  logic rst,
    input  logic d,
    output logic q
);

    logic meta_ff;

    // =====================================================================
    // two-stage level synchroniser; the first stage feeds only the second
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_ff <= RST_VAL;
            q       <= RST_VAL;
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end

endmodule
